/* File: src/control_mode_config_select.sv */
// Control mode selection and per-feature routing from straps or registers.
// Assumes strap pins report level, and the select, mode, edge and delay straps
// a mid-level (floating) indication, from their pads; all pins are asynchronous to sys_clk_i.
`timescale 1ns/1ps
// Behaviour
// RULE1: Extended mode whenever the extended select pin is driven low.
// RULE2: Select floating, second strap floating or high: range pin enables.
// RULE3: System keeps the mode choice fixed while operating.
// RULE4: SDR/DDR from edge strap, or config bit 10 in extended mode.
// RULE5: DDR clock phase fixed 0 degrees, or config bit 11 in extended.
// RULE6: SDR edge from edge strap level, or config bit 8 in extended.
// RULE7: Output swing from swing strap, or config bit 9 in extended.
// RULE8: Calibration delay from delay strap; extended mode is always short.
// RULE9: Range strap shared, or per-channel 9-bit range codes when extended.
// RULE10: Offset only in extended mode, 9-bit codes per channel.
// RULE11: Dual-edge sampling by floating strap, or extended bit 13.
// RULE12: Normal dual-edge samples in-phase only; extended may pick either.
// RULE13: Test pattern only in extended mode with extended bit 15 set.
// RULE14: Trim disable keeps data clocks running; extended mode only.
// RULE15: Extended DDR: edge bit one gives no demux, zero gives 1:2.
// RULE16: Extended, second-clock bit zero turns range outputs into a clock.
// RULE17: Sample phase adjust only extended: coarse 15..7, fine 15..8.
// RULE18: Reset defaults: DDR, 0 degree phase, high swing, short delay.
// RULE19: Reset defaults: nominal range, no offset, features off, 1:2 demux.
// RULE20: Frames: 32 bits MSB first, header, 4-bit address, 16 data.
// RULE21: Registers have no effect while in normal control mode.
// RULE22: Host writes all nine registers first, singles afterwards.
module control_mode_config_select (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic scs_n_i,
  input wire logic ext_sel_n_i,
  input wire logic ext_sel_float_i,
  input wire logic mode_strap_i,
  input wire logic mode_strap_float_i,
  input wire logic range_strap_i,
  input wire logic edge_strap_i,
  input wire logic edge_strap_float_i,
  input wire logic swing_strap_i,
  input wire logic delay_strap_i,
  input wire logic delay_strap_float_i,
  output logic extended_mode_o,
  output logic ddr_mode_o,
  output logic ddr_clock_phase_sel_o,
  output logic data_on_rising_o,
  output logic output_swing_sel_o,
  output logic cal_delay_long_o,
  output logic range_reduced_o,
  output logic [8:0] range_code_i_o,
  output logic [8:0] range_code_q_o,
  output logic [8:0] offset_code_i_o,
  output logic [8:0] offset_code_q_o,
  output logic dual_edge_en_o,
  output logic dual_edge_q_sel_o,
  output logic test_pattern_out_en_o,
  output logic trim_disable_o,
  output logic demux_1to2_o,
  output logic second_out_clock_o,
  output logic phase_adj_en_o,
  output logic [8:0] phase_coarse_o,
  output logic [7:0] phase_fine_o,
  output logic cal_request_o
);
  import ctrl_mode_pkg::*;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  localparam int P_EXT_N = 3;
  localparam int P_EXT_FL = 4;
  localparam int P_MODE = 5;
  localparam int P_MODE_FL = 6;
  localparam int P_RANGE = 7;
  localparam int P_EDGE = 8;
  localparam int P_EDGE_FL = 9;
  localparam int P_SWING = 10;
  localparam int P_DELAY = 11;
  localparam int P_DELAY_FL = 12;

  logic [PIN_NUM-1:0] pin_raw;
  logic [PIN_NUM-1:0] sync1_r;
  logic [PIN_NUM-1:0] sync2_r;
  logic [PIN_NUM-1:0] sync3_r;
  logic [PIN_NUM-1:0] pin_r;

  assign pin_raw = {delay_strap_float_i, delay_strap_i, swing_strap_i,
                    edge_strap_float_i, edge_strap_i, range_strap_i,
                    mode_strap_float_i, mode_strap_i, ext_sel_float_i,
                    ext_sel_n_i, scs_n_i, sdata_i, sclk_i};

  // Reset level of every stage: normal mode, chip select high, and
  // straps that give the reset values of the feature outputs, so no
  // false mode, serial edge or output step follows the reset release
  localparam logic [PIN_NUM-1:0] PIN_IDLE = 13'h068C;

  // Three stages; a change is accepted only once stages two and three
  // agree, which costs a cycle but rejects single-sample glitches
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sync1_r <= PIN_IDLE;
      sync2_r <= PIN_IDLE;
      sync3_r <= PIN_IDLE;
      pin_r <= PIN_IDLE;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int k = 0; k < PIN_NUM; k++) begin
        if (sync2_r[k] == sync3_r[k]) begin
          pin_r[k] <= sync3_r[k];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Control mode decision
  // --------------------------------------------------------------------
  logic ext_mode;
  logic range_as_enable;

  // Floating select with the second strap floating or high hands the
  // enable to the range pin; here a low range pin enables extended mode
  assign range_as_enable = pin_r[P_EXT_FL] &
                           (pin_r[P_MODE_FL] | pin_r[P_MODE]); // see RULE2
  assign ext_mode = (!pin_r[P_EXT_FL] && !pin_r[P_EXT_N]) || // see RULE1
                    (range_as_enable && !pin_r[P_RANGE]);    // see RULE2
  // Mode is followed continuously; a fixed strap is assumed (see RULE3)

  // --------------------------------------------------------------------
  // Serial port and registers, live only in extended mode
  // --------------------------------------------------------------------
  logic wr;
  logic [3:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] cfg;
  logic [15:0] ext;
  logic [15:0] off_i;
  logic [15:0] fs_i;
  logic [15:0] off_q;
  logic [15:0] fs_q;
  logic [15:0] fine;
  logic [15:0] coarse;

  serial_frame_rx u_rx (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(ext_mode),
    .sclk_i(pin_r[PIN_SCLK]),
    .sdata_i(pin_r[PIN_SDATA]),
    .scs_n_i(pin_r[PIN_SCS_N]),
    .wr_o(wr),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  config_reg_bank u_regs (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .wr_i(wr),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data),
    .cfg_o(cfg),
    .ext_o(ext),
    .off_i_o(off_i),
    .fs_i_o(fs_i),
    .off_q_o(off_q),
    .fs_q_o(fs_q),
    .fine_o(fine),
    .coarse_o(coarse)
  );

  // Picks the 9-bit adjust field, zero outside extended mode
  function automatic logic [8:0] adj_field(input logic [15:0] r,
                                           input logic en);
    adj_field = en ? r[15:ADJ_LSB] : 9'h000;
  endfunction

  // --------------------------------------------------------------------
  // Feature routing, next values
  // --------------------------------------------------------------------
  logic ddr_nxt;
  logic edge_bit;

  assign edge_bit = cfg[EDGE_DEMUX_BIT];
  // A floating edge strap means DDR in normal mode
  assign ddr_nxt = ext_mode ? !cfg[DDR_SEL_N_BIT]   // see RULE4
                            : pin_r[P_EDGE_FL];     // see RULE4

  // --------------------------------------------------------------------
  // Registered feature outputs
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      extended_mode_o <= 1'b0;
      ddr_mode_o <= 1'b1;
      ddr_clock_phase_sel_o <= 1'b0;
      data_on_rising_o <= 1'b0;
      output_swing_sel_o <= 1'b1;
      cal_delay_long_o <= 1'b0;
      range_reduced_o <= 1'b0;
      dual_edge_en_o <= 1'b0;
      dual_edge_q_sel_o <= 1'b0;
      demux_1to2_o <= 1'b1;
    end else begin
      extended_mode_o <= ext_mode;
      ddr_mode_o <= ddr_nxt;
      // Phase is only meaningful in DDR; normal mode is 0 degrees only
      ddr_clock_phase_sel_o <= ext_mode & cfg[DDR_PHASE_BIT]; // see RULE5
      data_on_rising_o <= ext_mode ? edge_bit           // see RULE6
                                   : pin_r[P_EDGE];     // see RULE6
      output_swing_sel_o <= ext_mode ? cfg[SWING_BIT]   // see RULE7
                                     : pin_r[P_SWING];  // see RULE7
      cal_delay_long_o <= !ext_mode && !pin_r[P_DELAY_FL] &&
                          pin_r[P_DELAY];               // see RULE8
      range_reduced_o <= !ext_mode && !pin_r[P_RANGE];  // see RULE9
      dual_edge_en_o <= ext_mode ? ext[DES_EN_BIT]      // see RULE11
                                 : pin_r[P_DELAY_FL];   // see RULE11
      dual_edge_q_sel_o <= ext_mode & ext[DES_Q_SEL_BIT]; // see RULE12
      // Edge bit doubles as demux select only in extended DDR
      demux_1to2_o <= !(ext_mode && ddr_nxt && edge_bit); // see RULE15
    end
  end

  // Extended-only features; zero or off while in normal mode
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      range_code_i_o <= 9'h000;
      range_code_q_o <= 9'h000;
      offset_code_i_o <= 9'h000;
      offset_code_q_o <= 9'h000;
      test_pattern_out_en_o <= 1'b0;
      trim_disable_o <= 1'b0;
      second_out_clock_o <= 1'b0;
      phase_adj_en_o <= 1'b0;
      phase_coarse_o <= 9'h000;
      phase_fine_o <= 8'h00;
      cal_request_o <= 1'b0;
    end else begin
      range_code_i_o <= adj_field(fs_i, ext_mode);   // see RULE9
      range_code_q_o <= adj_field(fs_q, ext_mode);   // see RULE9
      offset_code_i_o <= adj_field(off_i, ext_mode); // see RULE10
      offset_code_q_o <= adj_field(off_q, ext_mode); // see RULE10
      test_pattern_out_en_o <= ext_mode & ext[TEST_PAT_BIT]; // see RULE13
      trim_disable_o <= ext_mode & ext[TRIM_DIS_BIT]; // see RULE14
      second_out_clock_o <= ext_mode & !cfg[SECOND_CLK_N_BIT]; // see RULE16
      phase_adj_en_o <= ext_mode;                    // see RULE17
      phase_coarse_o <= adj_field(coarse, ext_mode); // see RULE17
      phase_fine_o <= ext_mode ? fine[15:FINE_LSB] : 8'h00; // see RULE17
      // Registers are gated above, so normal mode sees none (see RULE21)
      cal_request_o <= wr && wr_addr == ADDR_CAL &&
                       wr_data[CAL_START_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_ext_select_low: assert property ( // see RULE1
    !pin_r[P_EXT_FL] && !pin_r[P_EXT_N] |=> extended_mode_o)
    else $error("extended mode not entered on low select");
  a_range_enable: assert property ( // see RULE2
    pin_r[P_EXT_FL] && pin_r[P_MODE] && pin_r[P_RANGE] |=> !extended_mode_o)
    else $error("range pin high must keep normal mode");
  a_ddr_source: assert property ( // see RULE4
    !ext_mode |=> ddr_mode_o == $past(pin_r[P_EDGE_FL]))
    else $error("normal mode DDR not from edge strap");
  a_phase_normal: assert property ( // see RULE5
    !extended_mode_o |-> $past(!ext_mode) ? !ddr_clock_phase_sel_o : 1'b1)
    else $error("normal mode phase must be zero");
  a_edge_normal: assert property ( // see RULE6
    !ext_mode ##1 !ext_mode |=> data_on_rising_o == $past(pin_r[P_EDGE]))
    else $error("edge select not from strap");
  a_swing_ext: assert property ( // see RULE7
    ext_mode |=> output_swing_sel_o == $past(cfg[SWING_BIT]))
    else $error("swing not from register");
  a_delay_ext: assert property ( // see RULE8
    extended_mode_o |-> !cal_delay_long_o)
    else $error("long delay in extended mode");
  a_offset_normal: assert property ( // see RULE10
    !extended_mode_o |-> offset_code_i_o == 9'h000 &&
                         offset_code_q_o == 9'h000)
    else $error("offset active in normal mode");
  a_test_pattern: assert property ( // see RULE13
    test_pattern_out_en_o |-> extended_mode_o)
    else $error("test pattern outside extended mode");
  a_demux_sel: assert property ( // see RULE15
    ext_mode && !cfg[DDR_SEL_N_BIT] && edge_bit |=> !demux_1to2_o)
    else $error("non-demux not selected");
  a_second_clk: assert property ( // see RULE16
    second_out_clock_o |-> extended_mode_o)
    else $error("second clock outside extended mode");
  a_frame_write: assert property ( // see RULE20
    wr |-> $past(ext_mode))
    else $error("register write outside extended mode");
  a_phase_gate: assert property ( // see RULE17
    !extended_mode_o |-> phase_coarse_o == 9'h000 && phase_fine_o == 8'h00)
    else $error("phase adjust in normal mode");
  a_range_strap: assert property ( // see RULE9
    !ext_mode |=> range_reduced_o == $past(!pin_r[P_RANGE]))
    else $error("reduced range not from strap");
  a_range_codes: assert property ( // see RULE9
    !extended_mode_o |-> range_code_i_o == 9'h000 &&
                         range_code_q_o == 9'h000)
    else $error("range codes active in normal mode");
  a_delay_strap: assert property ( // see RULE8
    !ext_mode |=> cal_delay_long_o ==
                  $past(!pin_r[P_DELAY_FL] && pin_r[P_DELAY]))
    else $error("calibration delay not from strap");
  a_dual_edge_ext: assert property ( // see RULE11
    ext_mode |=> dual_edge_en_o == $past(ext[DES_EN_BIT]))
    else $error("dual-edge enable not from register");
  a_q_select: assert property ( // see RULE12
    dual_edge_q_sel_o |-> extended_mode_o)
    else $error("quadrature pick outside extended mode");
  a_trim_ext: assert property ( // see RULE14
    trim_disable_o |-> extended_mode_o)
    else $error("trim disable outside extended mode");
  a_demux_sdr: assert property ( // see RULE15
    ext_mode && cfg[DDR_SEL_N_BIT] |=> demux_1to2_o)
    else $error("single rate must keep 1:2 demux");
  a_phase_enable: assert property ( // see RULE17
    phase_adj_en_o == extended_mode_o)
    else $error("phase adjust enable does not follow mode");
  a_cal_pulse: assert property ( // see RULE20
    cal_request_o |=> !cal_request_o)
    else $error("calibration request longer than one cycle");
  a_reg_hidden: assert property ( // see RULE21
    !ext_mode |=> !wr)
    else $error("register write accepted in normal mode");

  c_ext_entry: cover property (!extended_mode_o ##1 extended_mode_o);
  c_frame_write: cover property (wr && wr_addr == ADDR_CFG);
  c_non_demux: cover property (extended_mode_o && !demux_1to2_o);
  c_dual_edge: cover property (dual_edge_en_o && !extended_mode_o);
  c_cal_request: cover property (cal_request_o);

endmodule

/* File: src/ctrl_mode_pkg.sv */
// Shared constants for the control mode and feature routing block.
// Assumes a 200 MHz system clock and a three-wire serial register port.
package ctrl_mode_pkg;

  // ---------------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam logic [11:0] FRAME_HEADER = 12'h001;
  localparam logic [4:0] FRAME_LAST = 5'h1F;

  // ---------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_CAL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_OFF_I = 4'h2;
  localparam logic [3:0] ADDR_FS_I = 4'h3;
  localparam logic [3:0] ADDR_EXT = 4'h9;
  localparam logic [3:0] ADDR_OFF_Q = 4'hA;
  localparam logic [3:0] ADDR_FS_Q = 4'hB;
  localparam logic [3:0] ADDR_FINE = 4'hE;
  localparam logic [3:0] ADDR_COARSE = 4'hF;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CAL_START_BIT = 15;
  localparam int SECOND_CLK_N_BIT = 13;
  localparam int DDR_PHASE_BIT = 11;
  localparam int DDR_SEL_N_BIT = 10;
  localparam int SWING_BIT = 9;
  localparam int EDGE_DEMUX_BIT = 8;
  localparam int TEST_PAT_BIT = 15;
  localparam int TRIM_DIS_BIT = 14;
  localparam int DES_EN_BIT = 13;
  localparam int DES_Q_SEL_BIT = 12;
  localparam int ADJ_LSB = 7;
  localparam int FINE_LSB = 8;

  // ---------------------------------------------------------------------
  // Power-on values
  // ---------------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'hB2FF;
  localparam logic [15:0] EXT_RESET = 16'h0000;
  localparam logic [15:0] OFF_RESET = 16'h007F;
  localparam logic [15:0] FS_RESET = 16'h807F;
  localparam logic [15:0] PHASE_RESET = 16'h0000;

  // Strap vector positions, after synchronising
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_SCS_N = 2;
  localparam int PIN_NUM = 13;

endpackage

/* File: src/serial_frame_rx.sv */
// Receives 32-bit write frames from the three-wire serial port.
// Assumes synchronised, filtered levels of the serial pins.
`timescale 1ns/1ps
module serial_frame_rx (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic scs_n_i,
  output logic wr_o,
  output logic [3:0] wr_addr_o,
  output logic [15:0] wr_data_o
);
  import ctrl_mode_pkg::*;

  logic sclk_prev_r;
  logic [4:0] count_r;
  logic [30:0] shift_r;
  logic sclk_rise;

  assign sclk_rise = sclk_i & ~sclk_prev_r;

  // --------------------------------------------------------------------
  // Shifter: MSB first, next frame may start on the 33rd clock
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sclk_prev_r <= 1'b0;
      count_r <= 5'h00;
      shift_r <= 31'h00000000;
      wr_o <= 1'b0;
      wr_addr_o <= 4'h0;
      wr_data_o <= 16'h0000;
    end else begin
      sclk_prev_r <= sclk_i;
      wr_o <= 1'b0;
      if (scs_n_i || !enable_i) begin
        count_r <= 5'h00; // Deselect aborts a partial frame
      end else if (sclk_rise) begin
        shift_r <= {shift_r[29:0], sdata_i};
        count_r <= count_r + 5'h01; // Wraps for back-to-back frames
        if (count_r == FRAME_LAST &&
            shift_r[30:19] == FRAME_HEADER) begin // see RULE20
          wr_o <= 1'b1;
          wr_addr_o <= shift_r[18:15];
          wr_data_o <= {shift_r[14:0], sdata_i};
        end
      end
    end
  end

endmodule

/* File: src/config_reg_bank.sv */
// Write-only configuration registers with their power-on values.
// Assumes one-cycle write strobes from the frame receiver.
`timescale 1ns/1ps
module config_reg_bank (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wr_i,
  input wire logic [3:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] cfg_o,
  output logic [15:0] ext_o,
  output logic [15:0] off_i_o,
  output logic [15:0] fs_i_o,
  output logic [15:0] off_q_o,
  output logic [15:0] fs_q_o,
  output logic [15:0] fine_o,
  output logic [15:0] coarse_o
);
  import ctrl_mode_pkg::*;

  // --------------------------------------------------------------------
  // Storage, loaded with extended-mode defaults at reset
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cfg_o <= CFG_RESET; // see RULE18
      ext_o <= EXT_RESET; // see RULE19
      off_i_o <= OFF_RESET;
      fs_i_o <= FS_RESET;
      off_q_o <= OFF_RESET;
      fs_q_o <= FS_RESET;
      fine_o <= PHASE_RESET;
      coarse_o <= PHASE_RESET;
    end else if (wr_i) begin
      case (wr_addr_i)
        ADDR_CFG: cfg_o <= wr_data_i;
        ADDR_EXT: ext_o <= wr_data_i;
        ADDR_OFF_I: off_i_o <= wr_data_i;
        ADDR_FS_I: fs_i_o <= wr_data_i;
        ADDR_OFF_Q: off_q_o <= wr_data_i;
        ADDR_FS_Q: fs_q_o <= wr_data_i;
        ADDR_FINE: fine_o <= wr_data_i;
        ADDR_COARSE: coarse_o <= wr_data_i;
        default: ; // Reserved addresses are ignored
      endcase
    end
  end

endmodule

/* File: dv/strap_host_model.sv */
// Board strap and serial host model that drives every control pin.
// Assumes sys_clk_i is the 200 MHz system clock of the device.
`timescale 1ns/1ps
module strap_host_model (
  input wire logic sys_clk_i,
  output logic sclk_o,
  output logic sdata_o,
  output logic scs_n_o,
  output logic [9:0] pins_o
);
  // Idle: select high, SCLK standing low, straps in normal mode
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    scs_n_o = 1'b1;
    pins_o = 10'h2B4;
  end

  // Straps move only between frames, never mid-transfer
  task automatic set_pins(input logic [9:0] v);
    @(posedge sys_clk_i);
    pins_o <= v;
  endtask

  // One write frame; SCLK phases of 8 cycles keep setup and hold wide
  task automatic send_frame(input logic [11:0] hdr, input logic [3:0] adr,
      input logic [15:0] dat);
    logic [31:0] f;
    f = {hdr, adr, dat};
    @(posedge sys_clk_i);
    scs_n_o <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdata_o <= f[i];
      repeat (8) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      sclk_o <= 1'b0;
    end
  endtask

  // Released data line shows the inverse, never a stale level
  task automatic end_session();
    repeat (8) @(posedge sys_clk_i);
    scs_n_o <= 1'b1;
    sdata_o <= ~sdata_o;
  endtask
endmodule

/* File: dv/control_mode_config_select_test.sv */
// Self-checking bench for the control mode and feature routing block.
// Assumes the strap and host model is the only driver of the pins.
`timescale 1ns/1ps
module control_mode_config_select_test;
  import ctrl_mode_pkg::*;
  typedef struct packed {
    logic [9:0] pins;
    logic [12:0] exp;
  } row_t;
  // --------------------------------------------------------------------
  // Expected values
  // --------------------------------------------------------------------
  localparam logic [12:0] EXT_POR = 13'h1905;
  localparam logic [12:0] FLAGS_SET = 13'h1939;
  localparam logic [9:0] EXT_PINS = 10'h096;
  localparam logic [52:0] CODES_POR = {9'h100, 9'h100, 35'h0};
  localparam logic [52:0] CODES_SET = {9'h000, 9'h1FF, 9'h1FF, 9'h001,
      9'h157, 8'hC3};
  // Pins {sel_n,sel_fl,mode,mode_fl,range,edge,edge_fl,swing,dly,dly_fl}
  row_t rows [8] = '{{10'h2B4, 13'h0304}, {10'h282, 13'h00C4},
      {10'h2AD, 13'h0924}, {10'h096, 13'h1905}, {10'h340, 13'h1905},
      {10'h380, 13'h1905}, {10'h314, 13'h0344}, {10'h3B4, 13'h0304}};
  logic [19:0] init [9] = '{20'h07FFF, 20'h1B2FF, 20'h2007F, 20'h3807F,
      20'h90000, 20'hA007F, 20'hB807F, 20'hE0000, 20'hF0000};
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sclk, sdata, scs_n;
  logic [9:0] pins;
  logic ext_o, ddr_o, ph_o, rise_o, swing_o, long_o, red_o, des_o, qsel_o;
  logic tp_o, trim_o, demux_o, sec_o, padj_o, cal;
  logic [8:0] rng_i, rng_q, off_i, off_q, coarse;
  logic [7:0] fine;
  logic [12:0] flags;
  logic [52:0] codes;
  int errors = 0;
  int cmp_count = 0;
  int cal_seen = 0;

  assign flags = {ext_o, ddr_o, ph_o, rise_o, swing_o, long_o, red_o,
      des_o, tp_o, trim_o, demux_o, sec_o, padj_o};
  assign codes = {rng_i, rng_q, off_i, off_q, coarse, fine};

  // Calibration requests last one cycle, so they are counted here
  always @(posedge sys_clk_i) begin
    if (cal === 1'b1) begin
      cal_seen <= cal_seen + 1;
    end
  end

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  strap_host_model strap_host_model_i (.sys_clk_i(sys_clk_i),
      .sclk_o(sclk), .sdata_o(sdata), .scs_n_o(scs_n), .pins_o(pins));

  control_mode_config_select control_mode_config_select_i (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
      .sdata_i(sdata), .scs_n_i(scs_n), .ext_sel_n_i(pins[9]),
      .ext_sel_float_i(pins[8]), .mode_strap_i(pins[7]),
      .mode_strap_float_i(pins[6]), .range_strap_i(pins[5]),
      .edge_strap_i(pins[4]), .edge_strap_float_i(pins[3]),
      .swing_strap_i(pins[2]), .delay_strap_i(pins[1]),
      .delay_strap_float_i(pins[0]), .extended_mode_o(ext_o),
      .ddr_mode_o(ddr_o), .ddr_clock_phase_sel_o(ph_o),
      .data_on_rising_o(rise_o), .output_swing_sel_o(swing_o),
      .cal_delay_long_o(long_o), .range_reduced_o(red_o),
      .range_code_i_o(rng_i), .range_code_q_o(rng_q),
      .offset_code_i_o(off_i), .offset_code_q_o(off_q),
      .dual_edge_en_o(des_o), .dual_edge_q_sel_o(qsel_o),
      .test_pattern_out_en_o(tp_o), .trim_disable_o(trim_o),
      .demux_1to2_o(demux_o), .second_out_clock_o(sec_o),
      .phase_adj_en_o(padj_o), .phase_coarse_o(coarse),
      .phase_fine_o(fine), .cal_request_o(cal));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic chk(input string name, input logic [63:0] exp,
      input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Edge choice has no meaning under DDR, so it is masked there
  task automatic chk_flags(input logic [12:0] exp);
    logic [12:0] m;
    m = exp[11] ? 13'h1DFF : 13'h1FFF;
    chk("flags", 64'(exp & m), 64'(flags & m));
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    strap_host_model_i.send_frame(FRAME_HEADER, a, d);
  endtask

  task automatic done_wr();
    strap_host_model_i.end_session();
    settle(16);
  endtask

  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: a hang is counted and ends the run
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    chk("timeout", 64'h0, 64'h1);
    summarize();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    foreach (rows[k]) begin
      strap_host_model_i.set_pins(rows[k].pins);
      settle(8);
      chk_flags(rows[k].exp);
      chk("codes", 64'(rows[k].exp[12] ? CODES_POR : 53'h0),
          64'(codes));
    end
    // First session writes all nine registers back to back
    strap_host_model_i.set_pins(EXT_PINS);
    settle(8);
    foreach (init[k]) wr(init[k][19:16], init[k][15:0]);
    done_wr();
    chk_flags(EXT_POR);
    chk("codes", 64'(CODES_POR), 64'(codes));
    chk("cal_pulses", 64'h0, 64'(cal_seen));
    wr(ADDR_CFG, 16'h9DFF);
    done_wr();
    chk_flags(13'h1607);
    wr(ADDR_CFG, 16'hB3FF);
    wr(ADDR_EXT, 16'hF000);
    done_wr();
    chk_flags(FLAGS_SET);
    chk("q_select", 64'h1, 64'(qsel_o));
    // Bad header and a reserved address must leave everything alone
    strap_host_model_i.send_frame(12'h003, ADDR_CFG, 16'h9DFF);
    wr(4'h4, 16'hFFFF);
    wr(ADDR_CAL, 16'hFFFF);
    done_wr();
    chk_flags(FLAGS_SET);
    chk("cal_pulses", 64'h1, 64'(cal_seen));
    wr(ADDR_OFF_I, 16'hFF80);
    wr(ADDR_OFF_Q, 16'h0080);
    wr(ADDR_FS_I, 16'h0000);
    wr(ADDR_FS_Q, 16'hFFFF);
    wr(ADDR_COARSE, 16'hAB80);
    wr(ADDR_FINE, 16'hC300);
    done_wr();
    chk("codes", 64'(CODES_SET), 64'(codes));
    // Normal mode: registers hidden, serial port ignored
    strap_host_model_i.set_pins(rows[0].pins);
    settle(8);
    chk_flags(rows[0].exp);
    chk("codes", 64'h0, 64'(codes));
    chk("q_select", 64'h0, 64'(qsel_o));
    wr(ADDR_CFG, 16'h9DFF);
    wr(ADDR_CAL, 16'hFFFF);
    done_wr();
    strap_host_model_i.set_pins(EXT_PINS);
    settle(8);
    chk_flags(FLAGS_SET);
    chk("codes", 64'(CODES_SET), 64'(codes));
    chk("cal_pulses", 64'h1, 64'(cal_seen));
    // Reset in mid-run restores the power-on settings
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    settle(12);
    chk_flags(EXT_POR);
    chk("codes", 64'(CODES_POR), 64'(codes));
    summarize();
  end
endmodule
